// ==== verilog/status_pkg.sv ====
// Purpose: shared constants and types for the status indicator encoder
// Assumes: 20 MHz system clock
// Notes:   times in their own unit, cycle counts derived from them
package status_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned FLASH_MS      = 75;
  localparam int unsigned FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned VALID_MS      = 500;
  localparam int unsigned VALID_CYCLES  = CLK_HZ / 1000 * VALID_MS;
  localparam int unsigned FLASH_W       = 24;
  localparam int unsigned VALID_W       = 24;
  localparam logic [2:0]  LEDS_DARK     = 3'h7;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_CONNECTING,
    LINK_CONNECTED
  } link_state_t;

endpackage : status_pkg

// ==== verilog/status_if.sv ====
// Purpose: carries the flash timer request and state between modules
// Assumes: single clock domain
// Notes:   timer owns flashing and restart
`timescale 1ns/1ps
interface status_if;
  logic trigger;
  logic flashing;
  modport owner (output trigger, input flashing);
  modport timer (input trigger, output flashing);
endinterface : status_if

// ==== verilog/flash_timer.sv ====
// Purpose: times the blanking flash after data activity
// Assumes: trigger is a one-cycle pulse on clk
// Notes:   a new trigger restarts the count
`timescale 1ns/1ps
module flash_timer
  import status_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  status_if.timer   tmr
);

  typedef struct packed {
    logic [FLASH_W-1:0] count;
    logic               flashing;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;

  always_comb begin
    next_state = state;
    if (tmr.trigger) begin
      next_state.count    = FLASH_W'(FLASH_CYCLES - 1);
      next_state.flashing = 1'b1;
    end else if (state.flashing) begin
      if (state.count == '0) begin
        next_state.flashing = 1'b0;
      end else begin
        next_state.count = state.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tmr.flashing = state.flashing;

endmodule : flash_timer

// ==== verilog/status_indicator_encoder.sv ====
// Purpose: encodes mode and link state onto three active-low indicators
// Assumes: all status inputs come from logic on clk; activity is a level
// Notes:   outputs float (enable low) while rst_n is held
//          lamps and terminal ready follow the inputs one cycle later, data activity two cycles later
//          lamp bits are kept as {blue, red, green} throughout
//          a flash blanks lit lamps for the flash timer's full count
//          a rising activity edge during a flash restarts the count
//          an unused link state value shows every lamp dark
//          green valid rises once after reset and stays up
//          the startup count is restarted by nothing but reset
//          ready_on_link selects the terminal-ready link indication
//
// What this block does
// - indicator outputs are active low; low means lit
// - idle data green; idle command green+red; connecting blue+red; linked blue
// - data activity forces lit indicators high for 50 to 100 ms
// - optional mode drives terminal-ready low while a link is active
// - all outputs float while reset is held
// - green output is flagged valid only 500 ms after startup
`timescale 1ns/1ps
module status_indicator_encoder
  import status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        command_mode,
  input  wire link_state_t link_state,
  input  wire logic        data_activity,
  input  wire logic        ready_on_link,
  output logic             green_n,
  output logic             blue_n,
  output logic             red_n,
  output logic             term_ready_n,
  output logic             outputs_oe,
  output logic             green_valid
);

  // one register image of everything this module remembers
  typedef struct packed {
    logic [2:0]         leds_n;
    logic               term_ready_n;
    logic               oe;
    logic               act_prev;
    logic [VALID_W-1:0] valid_count;
    logic               valid;
  } enc_state_t;

  // lamp patterns as {blue, red, green}; a low bit lights a lamp
  localparam logic [2:0] CODE_IDLE_DATA  = 3'h6;
  localparam logic [2:0] CODE_IDLE_CMD   = 3'h4;
  localparam logic [2:0] CODE_CONNECTING = 3'h1;
  localparam logic [2:0] CODE_CONNECTED  = 3'h3;

  // value of the register image while reset is held
  localparam enc_state_t RESET_IMAGE = '{
    leds_n:       LEDS_DARK,
    term_ready_n: 1'b1,
    oe:           1'b0,
    act_prev:     1'b0,
    valid_count:  '0,
    valid:        1'b0
  };

  enc_state_t state;
  enc_state_t next_state;
  // carries the flash request to the timer and its state back
  status_if   flash_bus ();

  // helpers between the inputs and the register image
  logic       activity_rise;
  logic       link_up;
  logic       valid_done;
  logic [2:0] steady_leds_n;
  logic [2:0] shown_leds_n;
  logic [2:0] led_pins_n;

  // pattern for a mode and link state; an unused state shows all dark
  function automatic logic [2:0] encode_leds(input logic        cmd,
                                             input link_state_t ls);
    logic [2:0] code;
    code = LEDS_DARK;
    case (ls)
      LINK_IDLE: begin
        if (cmd) begin
          code = CODE_IDLE_CMD;
        end else begin
          code = CODE_IDLE_DATA;
        end
      end
      LINK_CONNECTING: begin
        code = CODE_CONNECTING;
      end
      LINK_CONNECTED: begin
        code = CODE_CONNECTED;
      end
      default: begin
        code = LEDS_DARK;
      end
    endcase
    encode_leds = code;
  endfunction : encode_leds

  // the link counts as active only once it is connected
  function automatic logic link_is_active(input link_state_t ls);
    logic active;
    active = 1'b0;
    case (ls)
      LINK_IDLE: begin
        active = 1'b0;
      end
      LINK_CONNECTING: begin
        active = 1'b0;
      end
      LINK_CONNECTED: begin
        active = 1'b1;
      end
      default: begin
        active = 1'b0;
      end
    endcase
    link_is_active = active;
  endfunction : link_is_active

  // during a flash every lamp that the pattern lights is forced high
  function automatic logic [2:0] flash_leds(input logic [2:0] code,
                                            input logic       flashing);
    logic [2:0] shown;
    shown = code;
    // lit bits go high, dark bits are high already
    for (int i = 0; i < 3; i++) begin
      if (!flashing) begin
        shown[i] = code[i];
      end else if (!code[i]) begin
        shown[i] = 1'b1;
      end else begin
        shown[i] = code[i];
      end
    end
    flash_leds = shown;
  endfunction : flash_leds

  // flash length counter; restarts on every new trigger
  flash_timer u_flash (
    .clk   (clk),
    .rst_n (rst_n),
    .tmr   (flash_bus.timer)
  );

  // a new rising edge of activity starts or restarts the flash
  assign activity_rise     = data_activity & ~state.act_prev;
  assign flash_bus.trigger = activity_rise;

  // decoded views of the inputs, used by the next-state logic
  assign steady_leds_n = encode_leds(command_mode,
                                     link_state);
  assign shown_leds_n  = flash_leds(steady_leds_n,
                                    flash_bus.flashing);
  assign link_up       = link_is_active(link_state);
  assign valid_done    = (state.valid_count == VALID_W'(VALID_CYCLES - 1));

  // next value of the register image
  always_comb begin
    // every field holds unless a line below changes it
    next_state.leds_n       = state.leds_n;
    next_state.term_ready_n = state.term_ready_n;
    next_state.oe           = state.oe;
    next_state.act_prev     = state.act_prev;
    next_state.valid_count  = state.valid_count;
    next_state.valid        = state.valid;

    // pins are driven from the first edge after reset lets go
    next_state.oe = 1'b1;

    // last activity level, for the edge detector
    next_state.act_prev = data_activity;

    // lamps follow mode and link state one cycle later
    next_state.leds_n = shown_leds_n;

    // terminal ready is low only with the option on and a link up
    if (ready_on_link && link_up) begin
      next_state.term_ready_n = 1'b0;
    end else begin
      next_state.term_ready_n = 1'b1;
    end

    // green is flagged valid once the startup interval has run out
    // the count stops once valid is up, so it never wraps
    if (!state.valid) begin
      if (valid_done) begin
        next_state.valid = 1'b1;
      end else begin
        next_state.valid_count = state.valid_count + 1'b1;
      end
    end
  end

  // reset parks every pin undriven, lamps dark and ready off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RESET_IMAGE;
    end else begin
      state <= next_state;
    end
  end

  // one flip-flop per lamp pin
  for (genvar i = 0; i < 3; i++) begin : g_led_pin
    assign led_pins_n[i] = state.leds_n[i];
  end

  // lamp pins
  assign green_n      = led_pins_n[0];
  assign red_n        = led_pins_n[1];
  assign blue_n       = led_pins_n[2];

  // terminal ready, pin enable and the startup flag
  assign term_ready_n = state.term_ready_n;
  assign outputs_oe   = state.oe;
  assign green_valid  = state.valid;

endmodule : status_indicator_encoder

// ==== tb/status_sva.sv ====
// Purpose: port checker for status_indicator_encoder
// Assumes: one clock, async active-low reset
// Notes:   flash end and 500 ms point lie past the run
`timescale 1ns/1ps
module status_sva
  import status_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        command_mode,
  input wire link_state_t link_state,
  input wire logic        data_activity,
  input wire logic        ready_on_link,
  input wire logic        green_n,
  input wire logic        blue_n,
  input wire logic        red_n,
  input wire logic        term_ready_n,
  input wire logic        outputs_oe,
  input wire logic        green_valid
);
  wire logic [2:0] leds = {blue_n, red_n, green_n};
  wire logic [2:0] enc = link_state == LINK_CONNECTED ? 3'h3 :
    link_state == LINK_CONNECTING ? 3'h1 : command_mode ? 3'h4 : 3'h6;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since reset let go, saturating well past the startup span
  logic [VALID_W:0] since_rel;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rel <= '0;
    end else if (!since_rel[VALID_W]) begin
      since_rel <= since_rel + 1'b1;
    end
  end
  a_green_early: assert property (
    green_valid |-> since_rel >= VALID_CYCLES) else $error("valid early");
  a_led_code: assert property (
    leds == 3'h7 || leds == $past(enc)) else $error("led code");
  a_blue_lit: assert property (
    $past(link_state == LINK_CONNECTED) && leds != 3'h7 |-> !blue_n)
    else $error("blue dark");
  a_flash_hold: assert property (
    $rose(data_activity) |-> ##2 leds == 3'h7 [*8]) else $error("flash");
  a_term_ready: assert property (
    $past(outputs_oe) |-> term_ready_n ==
    !$past(ready_on_link && link_state == LINK_CONNECTED)) else $error("dtr");
  a_reset_float: assert property (
    disable iff (1'b0) !rst_n [*2] |-> !outputs_oe) else $error("float");
  a_oe_up: assert property (
    $rose(rst_n) |-> ##1 outputs_oe) else $error("oe");
  a_green_late: assert property (
    $rose(rst_n) |-> ##1 !green_valid [*8]) else $error("valid");
endmodule : status_sva
bind status_indicator_encoder status_sva u_sva (.*);

// ==== tb/lamp_panel.sv ====
// Purpose: external lamps on the indicator pins
// Assumes: pins pulled up while undriven
// Notes:   lit is active high
`timescale 1ns/1ps
module lamp_panel (
  input  wire logic [2:0] pins_n,
  input  wire logic       oe,
  output logic      [2:0] lit
);
  assign lit = oe ? ~pins_n : 3'h0;
endmodule : lamp_panel

// ==== tb/status_indicator_encoder_tb.sv ====
// Purpose: bench for status_indicator_encoder
// Assumes: 20 MHz clk
// Notes:   lamps are {blue, red, green}
`timescale 1ns/1ps
module status_indicator_encoder_tb;
  import status_pkg::*;
  logic clk = 0, rst_n = 0, command_mode = 0, data_activity = 0;
  logic ready_on_link = 0, green_n, blue_n, red_n, term_ready_n;
  logic outputs_oe, green_valid;
  logic [2:0] lit;
  link_state_t link_state = LINK_IDLE;
  int error_cnt = 0, total_checks = 0;
  always #25 clk = ~clk;
  status_indicator_encoder DUT (.*);
  lamp_panel u_lamps (.pins_n({blue_n, red_n, green_n}), .oe(outputs_oe),
    .lit(lit));
  task automatic chk(string n, logic [2:0] e, logic [2:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic go(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : go
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic t_codes;
    link_state_t s [4] = '{LINK_IDLE, LINK_IDLE, LINK_CONNECTING,
      LINK_CONNECTED};
    logic [2:0] e [4] = '{3'h1, 3'h3, 3'h6, 3'h4};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      link_state <= s[i];
      command_mode <= i == 1;
      ready_on_link <= i[0];
      go(2);
      chk("lamps", e[i], lit);
      chk("ready", {2'h0, i != 3}, {2'h0, term_ready_n});
    end
    $display("t_codes done");
  endtask : t_codes
  task automatic t_flash;
    @(posedge clk);
    data_activity <= 1;
    go(2);
    chk("flash", 3'h0, lit);
    @(posedge clk);
    data_activity <= 0;
    go(1);
    @(posedge clk);
    data_activity <= 1;
    go(3);
    chk("restart", 3'h0, lit);
    $display("t_flash done");
  endtask : t_flash
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 0;
    data_activity <= 0;
    go(2);
    chk("float", 3'h0, {outputs_oe, green_valid, |lit});
    @(posedge clk);
    rst_n <= 1;
    go(2);
    chk("oe", 3'h6, {outputs_oe, ~green_valid, 1'b0});
    $display("t_reset done");
  endtask : t_reset
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_codes();
    t_flash();
    t_reset();
    final_report();
  end
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule : status_indicator_encoder_tb
